// file: logic/fcsc_pkg.sv
// Constants shared by the force-strobe and counter register block
//
// Contract
// RL1 - Force strobes act only in non-PWM modes
// RL2 - Writing one forces an immediate compare match
// RL3 - Forced match follows current output mode setting
// RL4 - Forced match sets no flag, no interrupt
// RL5 - Forced match never clears counter in clear-on-match
// RL6 - Force strobe bits always read as zero
// RL7 - Strobe bits: A at 7, B 6, C 5
// RL8 - Software writes zeros to reserved bits 4:0
// RL9 - Modes: 00 off, 01 toggle, 10 low, 11 high
// RL10 - Counter accessed through shared high-byte latch
// RL11 - Counter write suppresses next compare match
// RL12 - Each strobe lasts exactly one clock cycle
package fcsc_pkg;
  localparam int NUM_TIMERS = 4;
  localparam int NUM_CHAN = 3;
  localparam int NUM_OUT = NUM_TIMERS * NUM_CHAN;
  localparam int ADDR_W = 12;
  localparam int IDX_W = ADDR_W - 2;
  localparam int DATA_W = 32;
  localparam int STRB_W = DATA_W / 8;
  localparam int BYTE_W = 8;
  localparam int CNT_W = 16;
  localparam int COM_W = 2;
  localparam int WGM_W = 4;
  localparam int CTRL_W = 11;

  // Register indices; byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_FORCE [NUM_TIMERS] = '{10'h082, 10'h092, 10'h0a2, 10'h122};
  localparam logic [IDX_W-1:0] IDX_CTRL [NUM_TIMERS] = '{10'h080, 10'h090, 10'h0a0, 10'h120};
  localparam logic [IDX_W-1:0] IDX_CNT_LO [NUM_TIMERS] = '{10'h084, 10'h094, 10'h0a4, 10'h124};
  localparam logic [IDX_W-1:0] IDX_CNT_HI [NUM_TIMERS] = '{10'h085, 10'h095, 10'h0a5, 10'h125};

  // Strobe positions inside the force register, channel A first
  localparam int FORCE_BIT [NUM_CHAN] = '{7, 6, 5};

  // Mode register fields
  localparam int CTRL_WGM_LSB = 0;
  localparam int CTRL_COM_LSB = 4;
  localparam int CTRL_RUN_BIT = 10;

  localparam logic [CTRL_W-1:0] CTRL_RESET = 11'h000;
  localparam logic [CNT_W-1:0] CNT_RESET = 16'h0000;
  localparam logic [BYTE_W-1:0] TEMP_RESET = 8'h00;

  localparam logic [WGM_W-1:0] MODE_NORMAL = 4'h0;
  localparam logic [WGM_W-1:0] MODE_CTC_A = 4'h4;
  localparam logic [WGM_W-1:0] MODE_CTC_ICR = 4'hc;

  localparam logic [COM_W-1:0] COM_OFF = 2'h0;
  localparam logic [COM_W-1:0] COM_TOGGLE = 2'h1;
  localparam logic [COM_W-1:0] COM_CLEAR = 2'h2;
  localparam logic [COM_W-1:0] COM_SET = 2'h3;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  function automatic logic fcsc_non_pwm(input logic [WGM_W-1:0] mode);
    return (mode == MODE_NORMAL) || (mode == MODE_CTC_A) || (mode == MODE_CTC_ICR);
  endfunction
endpackage

// file: logic/fcsc_counter.sv
// One 16-bit timer counter with load and clear-on-match
`timescale 1ns/10ps
module fcsc_counter #(
  parameter int CNT_W = fcsc_pkg::CNT_W
) (
  input  wire logic             clk,
  input  wire logic             srst,
  input  wire logic             run,
  input  wire logic             clr,
  input  wire logic             wr,
  input  wire logic [CNT_W-1:0] wdata,
  output logic      [CNT_W-1:0] cnt
);
  import fcsc_pkg::*;

  // Software load beats the match clear so a write is never lost
  always_ff @(posedge clk) begin
    if (srst) begin
      cnt <= CNT_W'(CNT_RESET);
    end else if (wr) begin
      cnt <= wdata;
    end else if (clr) begin
      cnt <= '0;
    end else if (run) begin
      cnt <= cnt + 1'b1;
    end
  end
endmodule // fcsc_counter

// file: logic/fcsc_out_chan.sv
// Compare output pin of one channel, non-PWM behaviour
`timescale 1ns/10ps
module fcsc_out_chan (
  input  wire logic                       clk,
  input  wire logic                       srst,
  input  wire logic                       hit,
  input  wire logic                       active,
  input  wire logic [fcsc_pkg::COM_W-1:0] com,
  output logic                            pin,
  output logic                            pin_en
);
  import fcsc_pkg::*;

  always_ff @(posedge clk) begin
    if (srst) begin
      pin <= 1'b0;
    end else if (hit && active) begin
      case (com) // [RL9] [RL3]
        COM_TOGGLE: pin <= !pin;
        COM_CLEAR: pin <= 1'b0;
        COM_SET: pin <= 1'b1;
        default: pin <= pin;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      pin_en <= 1'b0;
    end else begin
      pin_en <= (com != COM_OFF);
    end
  end

  AST_COM_TOGGLE: assert property (@(posedge clk) disable iff (srst) // [RL9]
    hit && active && com == COM_TOGGLE |=> pin != $past(pin))
    else $error("toggle mode did not invert the pin");
  AST_COM_LEVEL: assert property (@(posedge clk) disable iff (srst) // [RL3]
    hit && active && com[1] |=> pin == $past(com[0]))
    else $error("clear or set mode gave wrong pin level");
endmodule // fcsc_out_chan

// file: logic/fcsc_top.sv
// Force-strobe and counter registers of four timers behind AXI4-Lite
//
// The AXI4-Lite interface to the registers was chosen for this implementation.
`timescale 1ns/10ps
module fcsc_top (
  input  wire logic                          CLK,
  input  wire logic                          SRST,
  input  wire logic [fcsc_pkg::ADDR_W-1:0]   AWADDR,
  input  wire logic [2:0]                    AWPROT,
  input  wire logic                          AWVALID,
  output logic                               AWREADY,
  input  wire logic [fcsc_pkg::DATA_W-1:0]   WDATA,
  input  wire logic [fcsc_pkg::STRB_W-1:0]   WSTRB,
  input  wire logic                          WVALID,
  output logic                               WREADY,
  output logic      [1:0]                    BRESP,
  output logic                               BVALID,
  input  wire logic                          BREADY,
  input  wire logic [fcsc_pkg::ADDR_W-1:0]   ARADDR,
  input  wire logic [2:0]                    ARPROT,
  input  wire logic                          ARVALID,
  output logic                               ARREADY,
  output logic      [fcsc_pkg::DATA_W-1:0]   RDATA,
  output logic      [1:0]                    RRESP,
  output logic                               RVALID,
  input  wire logic                          RREADY,
  input  wire logic [fcsc_pkg::NUM_OUT-1:0]  REAL_MATCH,
  output logic      [fcsc_pkg::NUM_OUT-1:0]  COMPARE_OUT,
  output logic      [fcsc_pkg::NUM_OUT-1:0]  COMPARE_OUT_EN,
  output logic      [fcsc_pkg::NUM_OUT-1:0]  MATCH_FLAG
);
  import fcsc_pkg::*;

  logic aw_full;
  logic w_full;
  logic next_aw_full;
  logic next_w_full;
  logic wr_fire;
  logic wr_hit;
  logic rd_take;
  logic rd_hit;
  logic [ADDR_W-1:0] aw_addr;
  logic [DATA_W-1:0] w_data;
  logic [STRB_W-1:0] w_strb;
  logic [IDX_W-1:0] wr_idx;
  logic [IDX_W-1:0] rd_idx;
  logic [DATA_W-1:0] rd_data;
  logic [BYTE_W-1:0] rd_latch;
  logic [BYTE_W-1:0] temp;
  logic [CNT_W-1:0] cnt_wdata;
  logic [CTRL_W-1:0] ctrl [NUM_TIMERS];
  logic [CNT_W-1:0] cnt [NUM_TIMERS];
  logic [NUM_TIMERS-1:0] wr_force;
  logic [NUM_TIMERS-1:0] wr_ctrl;
  logic [NUM_TIMERS-1:0] wr_hi;
  logic [NUM_TIMERS-1:0] cnt_wr;
  logic [NUM_TIMERS-1:0] rd_lo;
  logic [NUM_TIMERS-1:0] suppress;
  logic [NUM_TIMERS-1:0] non_pwm;
  logic [NUM_TIMERS-1:0][NUM_CHAN-1:0] force_pulse;
  logic [NUM_OUT-1:0] gated;

  default clocking cb @(posedge CLK); endclocking
  default disable iff (SRST);

  ////////////////////////////////////////////////////////////////////
  // Write channels: address and data are held until both are in

  always_comb begin
    next_aw_full = aw_full;
    if (AWVALID && AWREADY) begin
      next_aw_full = 1'b1;
    end else if (wr_fire) begin
      next_aw_full = 1'b0;
    end
  end

  always_comb begin
    next_w_full = w_full;
    if (WVALID && WREADY) begin
      next_w_full = 1'b1;
    end else if (wr_fire) begin
      next_w_full = 1'b0;
    end
  end

  always_ff @(posedge CLK) begin
    if (SRST) begin
      aw_full <= 1'b0;
      AWREADY <= 1'b0;
      aw_addr <= '0;
    end else begin
      aw_full <= next_aw_full;
      AWREADY <= !next_aw_full;
      if (AWVALID && AWREADY) begin
        aw_addr <= AWADDR;
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (SRST) begin
      w_full <= 1'b0;
      WREADY <= 1'b0;
      w_data <= '0;
      w_strb <= '0;
    end else begin
      w_full <= next_w_full;
      WREADY <= !next_w_full;
      if (WVALID && WREADY) begin
        w_data <= WDATA;
        w_strb <= WSTRB;
      end
    end
  end

  // Holding off while a response waits keeps one write in flight
  assign wr_fire = aw_full && w_full && !BVALID;
  assign wr_idx = aw_addr[ADDR_W-1:2];
  assign cnt_wdata = {temp, w_data[BYTE_W-1:0]}; // [RL10]

  always_ff @(posedge CLK) begin
    if (SRST) begin
      BVALID <= 1'b0;
      BRESP <= RESP_OKAY;
    end else if (wr_fire) begin
      BVALID <= 1'b1;
      BRESP <= wr_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (BREADY) begin
      BVALID <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Write decode; only strobe bit 0 enables a write, and the mode register also takes data bits 10:8

  always_comb begin
    wr_hit = 1'b0;
    wr_force = '0;
    wr_ctrl = '0;
    wr_hi = '0;
    cnt_wr = '0;
    for (int t = 0; t < NUM_TIMERS; t++) begin
      if (wr_idx == IDX_FORCE[t]) begin
        wr_hit = 1'b1;
        wr_force[t] = wr_fire && w_strb[0];
      end else if (wr_idx == IDX_CTRL[t]) begin
        wr_hit = 1'b1;
        wr_ctrl[t] = wr_fire && w_strb[0];
      end else if (wr_idx == IDX_CNT_LO[t]) begin
        wr_hit = 1'b1;
        cnt_wr[t] = wr_fire && w_strb[0]; // [RL10]
      end else if (wr_idx == IDX_CNT_HI[t]) begin
        wr_hit = 1'b1;
        wr_hi[t] = wr_fire && w_strb[0]; // [RL10]
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Read channel, one cycle from address to data

  assign rd_take = ARVALID && ARREADY;
  assign rd_idx = ARADDR[ADDR_W-1:2];

  always_comb begin
    rd_hit = 1'b0;
    rd_data = '0;
    rd_lo = '0;
    rd_latch = temp;
    for (int t = 0; t < NUM_TIMERS; t++) begin
      if (rd_idx == IDX_FORCE[t]) begin
        rd_hit = 1'b1; // [RL6]
      end else if (rd_idx == IDX_CTRL[t]) begin
        rd_hit = 1'b1;
        rd_data = {21'h000000, ctrl[t]};
      end else if (rd_idx == IDX_CNT_LO[t]) begin
        rd_hit = 1'b1;
        rd_lo[t] = rd_take;
        rd_data = {24'h000000, cnt[t][BYTE_W-1:0]};
        rd_latch = cnt[t][CNT_W-1:BYTE_W]; // [RL10]
      end else if (rd_idx == IDX_CNT_HI[t]) begin
        rd_hit = 1'b1;
        rd_data = {24'h000000, temp}; // [RL10]
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (SRST) begin
      RVALID <= 1'b0;
      RDATA <= '0;
      RRESP <= RESP_OKAY;
    end else if (rd_take) begin
      RVALID <= 1'b1;
      RDATA <= rd_data;
      RRESP <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (RREADY) begin
      RVALID <= 1'b0;
    end
  end

  always_ff @(posedge CLK) begin
    if (SRST) begin
      ARREADY <= 1'b0;
    end else begin
      ARREADY <= !rd_take && (!RVALID || RREADY);
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Shared high-byte latch; a high-byte write beats a low-byte read

  always_ff @(posedge CLK) begin
    if (SRST) begin
      temp <= TEMP_RESET;
    end else if (|wr_hi) begin
      temp <= w_data[BYTE_W-1:0]; // [RL10]
    end else if (|rd_lo) begin
      temp <= rd_latch; // [RL10]
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Per-timer mode, counter, strobes and output channels

  for (genvar t = 0; t < NUM_TIMERS; t++) begin : g_tmr
    assign non_pwm[t] = fcsc_non_pwm(ctrl[t][CTRL_WGM_LSB +: WGM_W]);

    always_ff @(posedge CLK) begin
      if (SRST) begin
        ctrl[t] <= CTRL_RESET;
      end else if (wr_ctrl[t]) begin
        ctrl[t] <= w_data[CTRL_W-1:0];
      end
    end

    // The comparators see the loaded value one cycle late, so block them
    always_ff @(posedge CLK) begin
      if (SRST) begin
        suppress[t] <= 1'b0;
      end else begin
        suppress[t] <= cnt_wr[t]; // [RL11]
      end
    end

    // Only a real match on A may clear; strobes never reach here
    fcsc_counter #(
      .CNT_W (CNT_W)
    ) u_cnt (
      .clk   (CLK),
      .srst  (SRST),
      .run   (ctrl[t][CTRL_RUN_BIT]),
      .clr   (gated[t*NUM_CHAN] && ctrl[t][CTRL_WGM_LSB +: WGM_W] == MODE_CTC_A), // [RL5]
      .wr    (cnt_wr[t]),
      .wdata (cnt_wdata),
      .cnt   (cnt[t])
    );

    for (genvar c = 0; c < NUM_CHAN; c++) begin : g_ch
      // Reserved bits 4:0 are ignored whatever software writes
      always_ff @(posedge CLK) begin
        if (SRST) begin
          force_pulse[t][c] <= 1'b0;
        end else begin
          force_pulse[t][c] <= wr_force[t] && w_data[FORCE_BIT[c]] && non_pwm[t]; // [RL1] [RL2] [RL7] [RL12]
        end
      end

      assign gated[t*NUM_CHAN+c] = REAL_MATCH[t*NUM_CHAN+c] && !suppress[t]; // [RL11]

      // Flags come from real matches alone
      always_ff @(posedge CLK) begin
        if (SRST) begin
          MATCH_FLAG[t*NUM_CHAN+c] <= 1'b0;
        end else begin
          MATCH_FLAG[t*NUM_CHAN+c] <= gated[t*NUM_CHAN+c]; // [RL4]
        end
      end

      fcsc_out_chan u_out (
        .clk    (CLK),
        .srst   (SRST),
        .hit    (gated[t*NUM_CHAN+c] || force_pulse[t][c]), // [RL2] [RL3]
        .active (non_pwm[t]),
        .com    (ctrl[t][CTRL_COM_LSB+COM_W*c +: COM_W]),
        .pin    (COMPARE_OUT[t*NUM_CHAN+c]),
        .pin_en (COMPARE_OUT_EN[t*NUM_CHAN+c])
      );

      AST_FORCE_ONLY_NON_PWM: assert property ( // [RL1]
        force_pulse[t][c] |-> $past(non_pwm[t]))
        else $error("strobe raised in a PWM mode");

      AST_FORCE_FROM_WRITE: assert property ( // [RL2]
        wr_force[t] && w_data[FORCE_BIT[c]] && non_pwm[t] |=> force_pulse[t][c])
        else $error("written strobe did not fire");

      AST_FORCE_ONE_CYCLE: assert property ( // [RL12]
        force_pulse[t][c] |=> !force_pulse[t][c])
        else $error("strobe lasted more than one cycle");

      AST_FORCE_NO_FLAG: assert property ( // [RL4]
        force_pulse[t][c] && !gated[t*NUM_CHAN+c] |=> !MATCH_FLAG[t*NUM_CHAN+c])
        else $error("forced match raised a flag");
    end

    AST_FORCE_NO_CLEAR: assert property ( // [RL5]
      force_pulse[t][0] && !gated[t*NUM_CHAN] && !cnt_wr[t] && ctrl[t][CTRL_RUN_BIT]
      && cnt[t] != 16'hffff |=> cnt[t] == $past(cnt[t]) + 16'h0001)
      else $error("forced match cleared the counter");

    AST_CNT_LOAD: assert property ( // [RL10]
      cnt_wr[t] |=> cnt[t] == $past(cnt_wdata))
      else $error("counter write lost its latched high byte");

    AST_SUPPRESS: assert property ( // [RL11]
      cnt_wr[t] |=> ##1 MATCH_FLAG[t*NUM_CHAN +: NUM_CHAN] == 3'h0)
      else $error("match after counter write not suppressed");

    AST_LATCH_ON_LOW_READ: assert property ( // [RL10]
      rd_lo[t] && !(|wr_hi) |=> temp == $past(cnt[t][CNT_W-1:BYTE_W]))
      else $error("low-byte read did not latch the high byte");

    COV_FORCE_A: cover property (force_pulse[t][0]);
    COV_CNT_WRITE: cover property (cnt_wr[t] ##2 !suppress[t]);
    COV_LOW_READ: cover property (rd_lo[t]);
  end

  ////////////////////////////////////////////////////////////////////
  // Bus-level checks

  AST_FORCE_READS_ZERO: assert property ( // [RL6]
    rd_take && (rd_idx == IDX_FORCE[0] || rd_idx == IDX_FORCE[3]) |=> RDATA == 32'h00000000)
    else $error("strobe register read back nonzero");

  AST_READ_ANSWER: assert property (
    rd_take |=> RVALID)
    else $error("read not answered in one cycle");

  COV_BAD_ADDR: cover property (BVALID && BRESP == RESP_SLVERR);
endmodule // fcsc_top

// file: verification/tb_top.sv
// Self-checking bench for the force-strobe and counter register block
`timescale 1ns/10ps
module tb_top;
  import fcsc_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    logic             wr;
    logic [IDX_W-1:0] idx;
    logic [31:0]      wd;
    logic [31:0]      rd;
    logic [1:0]       rsp;
  } fcsc_row_t;

  // Rows read back after a write where the row asks for one; the unmapped row expects refusal on both channels
  localparam fcsc_row_t ROWS [6] = '{
    '{1'b0, IDX_CTRL[0], 32'h0, 32'h0, RESP_OKAY},
    '{1'b0, IDX_CNT_LO[3], 32'h0, 32'h0, RESP_OKAY},
    '{1'b1, IDX_CTRL[1], 32'h3f4, 32'h3f4, RESP_OKAY},
    '{1'b1, IDX_FORCE[2], 32'he0, 32'h0, RESP_OKAY},
    '{1'b1, 10'h000, 32'h5a, 32'h0, RESP_SLVERR},
    '{1'b1, IDX_CTRL[3], 32'h7ff, 32'h7ff, RESP_OKAY}};
  localparam logic [3:0] WL [4] = '{MODE_NORMAL, MODE_CTC_A, MODE_CTC_ICR, 4'h1};
  localparam logic [1:0] CL [4] = '{COM_OFF, COM_TOGGLE, COM_SET, COM_CLEAR};

  logic                CLK;
  logic                SRST;
  logic                AWVALID;
  logic                WVALID;
  logic                BREADY;
  logic                ARVALID;
  logic                RREADY;
  logic [ADDR_W-1:0]   AWADDR;
  logic [ADDR_W-1:0]   ARADDR;
  logic [DATA_W-1:0]   WDATA;
  logic [STRB_W-1:0]   WSTRB;
  logic [NUM_OUT-1:0]  REAL_MATCH;
  logic                AWREADY;
  logic                WREADY;
  logic                BVALID;
  logic                ARREADY;
  logic                RVALID;
  logic [1:0]          BRESP;
  logic [1:0]          RRESP;
  logic [DATA_W-1:0]   RDATA;
  logic [NUM_OUT-1:0]  COMPARE_OUT;
  logic [NUM_OUT-1:0]  COMPARE_OUT_EN;
  logic [NUM_OUT-1:0]  MATCH_FLAG;
  int                  miscompares = 0;
  int                  num_checks = 0;
  int                  flag_cnt = 0;

  fcsc_top i_fcsc_top (
    .CLK, .SRST, .AWADDR, .AWPROT(3'h0), .AWVALID, .AWREADY, .WDATA, .WSTRB, .WVALID, .WREADY,
    .BRESP, .BVALID, .BREADY, .ARADDR, .ARPROT(3'h0), .ARVALID, .ARREADY, .RDATA, .RRESP,
    .RVALID, .RREADY, .REAL_MATCH, .COMPARE_OUT, .COMPARE_OUT_EN, .MATCH_FLAG
  );

  initial begin
    CLK = 1'b0;
    forever #12.5 CLK = ~CLK;
  end

  // Flags are counted rather than sampled so a stray pulse is never missed
  always @(posedge CLK) begin
    if (!SRST) flag_cnt <= flag_cnt + $countones(MATCH_FLAG);
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic close_out();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic chk_val(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chk_resp(input string nm, input logic [1:0] e, input logic [1:0] g);
    num_checks++;
    if (g !== e) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic hang();
    miscompares++;
    $display("wrong value wait limit expected answer seen none");
    close_out();
  endtask

  task automatic axi_wr(input logic [IDX_W-1:0] ix, input logic [31:0] d, output logic [1:0] r);
    int n;
    AWADDR  <= {ix, 2'b00};
    WDATA   <= d;
    AWVALID <= 1'b1;
    WVALID  <= 1'b1;
    for (n = 0; n < 100; n++) begin
      @(posedge CLK);
      if (AWVALID && AWREADY) AWVALID <= 1'b0;
      if (WVALID && WREADY) WVALID <= 1'b0;
      if (BVALID) break;
    end
    if (n == 100) hang();
    r = BRESP;
  endtask

  task automatic axi_rd(input logic [IDX_W-1:0] ix, output logic [31:0] d, output logic [1:0] r);
    int n;
    ARADDR  <= {ix, 2'b00};
    ARVALID <= 1'b1;
    for (n = 0; n < 100; n++) begin
      @(posedge CLK);
      if (ARVALID && ARREADY) ARVALID <= 1'b0;
      if (RVALID) break;
    end
    if (n == 100) hang();
    d = RDATA;
    r = RRESP;
  endtask

  task automatic wr(input logic [IDX_W-1:0] ix, input logic [31:0] d);
    logic [1:0] r;
    axi_wr(ix, d, r);
    chk_resp("write response", RESP_OKAY, r);
  endtask

  task automatic rd_cnt(input int t, output logic [15:0] v);
    logic [31:0] lo;
    logic [31:0] hi;
    logic [1:0]  r;
    axi_rd(IDX_CNT_LO[t], lo, r);
    axi_rd(IDX_CNT_HI[t], hi, r);
    v = {hi[7:0], lo[7:0]};
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge CLK);
    #1;
  endtask

  task automatic pulse_match();
    REAL_MATCH[0] <= 1'b1;
    @(posedge CLK);
    REAL_MATCH[0] <= 1'b0;
  endtask

  // Match lands in the cycle right after the counter load, the only one that must be blocked
  task automatic match_after_take();
    int n;
    for (n = 0; n < 100; n++) begin
      @(posedge CLK);
      if (WVALID && WREADY) break;
    end
    if (n == 100) hang();
    @(posedge CLK);
    REAL_MATCH[0] <= 1'b1;
    @(posedge CLK);
    REAL_MATCH[0] <= 1'b0;
  endtask

  function automatic logic [31:0] mk(logic [1:0] cm, logic [3:0] wgm);
    return {21'h0, 1'b0, cm, cm, cm, wgm};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [31:0] d;
    logic [1:0]  r;
    logic [15:0] v;
    logic [2:0]  ex;
    int          f0;
    SRST = 1'b1;
    AWVALID = 1'b0;
    WVALID = 1'b0;
    // Answers are accepted whenever they come, so ready never toggles
    BREADY = 1'b1;
    ARVALID = 1'b0;
    RREADY = 1'b1;
    AWADDR = '0;
    ARADDR = '0;
    WDATA = '0;
    WSTRB = 4'hf;
    REAL_MATCH = '0;
    repeat (3) @(posedge CLK);
    SRST <= 1'b0;
    settle(2);
    foreach (ROWS[i]) begin
      if (ROWS[i].wr) begin
        axi_wr(ROWS[i].idx, ROWS[i].wd, r);
        chk_resp("row write response", ROWS[i].rsp, r);
      end
      axi_rd(ROWS[i].idx, d, r);
      chk_val("row read data", ROWS[i].rd, d);
      chk_resp("row read response", ROWS[i].rsp, r);
    end
    WSTRB <= 4'he;
    axi_wr(IDX_CTRL[2], 32'h55, r);
    WSTRB <= 4'hf;
    chk_resp("masked write response", RESP_OKAY, r);
    axi_rd(IDX_CTRL[2], d, r);
    chk_val("masked write ignored", 32'h0, d);
    $display("test register table done");
    f0 = flag_cnt;
    ex = 3'b000;
    wr(IDX_CTRL[0], mk(COM_TOGGLE, MODE_NORMAL));
    for (int c = 0; c < NUM_CHAN; c++) begin
      wr(IDX_FORCE[0], 32'(1) << FORCE_BIT[c]);
      settle(2);
      ex[c] = ~ex[c];
      chk_val("pins after one strobe", 32'(ex), 32'(COMPARE_OUT[2:0]));
    end
    $display("test single strobes done");
    foreach (CL[k]) begin
      wr(IDX_CTRL[0], mk(CL[k], MODE_NORMAL));
      wr(IDX_FORCE[0], 32'he0);
      settle(2);
      case (CL[k])
        COM_TOGGLE: ex = ~ex;
        COM_SET:    ex = 3'b111;
        COM_CLEAR:  ex = 3'b000;
        default:    ex = ex;
      endcase
      chk_val("pins per output mode", 32'(ex), 32'(COMPARE_OUT[2:0]));
      chk_val("pin enables", (CL[k] == COM_OFF) ? 32'h0 : 32'h7, 32'(COMPARE_OUT_EN[2:0]));
    end
    $display("test output modes done");
    foreach (WL[m]) begin
      wr(IDX_CTRL[0], mk(COM_TOGGLE, WL[m]));
      wr(IDX_FORCE[0], 32'he0);
      settle(2);
      if (m < 3) ex = ~ex;
      chk_val("pins per waveform mode", 32'(ex), 32'(COMPARE_OUT[2:0]));
    end
    chk_val("flags after strobes", 32'(f0), 32'(flag_cnt));
    $display("test waveform modes done");
    // Channel A toggles only; counter held still so its value is exact
    wr(IDX_CTRL[0], {21'h0, 1'b0, COM_OFF, COM_OFF, COM_TOGGLE, MODE_CTC_A});
    wr(IDX_CNT_HI[0], 32'h12);
    fork
      wr(IDX_CNT_LO[0], 32'h34);
      match_after_take();
    join
    settle(2);
    rd_cnt(0, v);
    chk_val("count after load", 32'h1234, 32'(v));
    axi_rd(IDX_CNT_HI[1], d, r);
    chk_val("shared high latch", 32'h12, d);
    chk_val("flags after blocked match", 32'(f0), 32'(flag_cnt));
    chk_val("pin after blocked match", 32'(ex[0]), 32'(COMPARE_OUT[0]));
    wr(IDX_FORCE[0], 32'h80);
    settle(2);
    ex[0] = ~ex[0];
    rd_cnt(0, v);
    chk_val("count after strobe", 32'h1234, 32'(v));
    chk_val("pin after strobe", 32'(ex[0]), 32'(COMPARE_OUT[0]));
    pulse_match();
    settle(2);
    ex[0] = ~ex[0];
    rd_cnt(0, v);
    chk_val("count after real match", 32'h0, 32'(v));
    chk_val("flags after real match", 32'(f0 + 1), 32'(flag_cnt));
    chk_val("pin after real match", 32'(ex[0]), 32'(COMPARE_OUT[0]));
    // Running counter: a clearing strobe would show as zero at the next read
    wr(IDX_CTRL[0], {21'h0, 1'b1, COM_OFF, COM_OFF, COM_TOGGLE, MODE_CTC_A});
    wr(IDX_FORCE[0], 32'h80);
    rd_cnt(0, v);
    chk_val("running count after strobe", 32'h1, 32'(v != 16'h0000));
    $display("test counter and suppression done");
    SRST <= 1'b1;
    repeat (3) @(posedge CLK);
    SRST <= 1'b0;
    settle(1);
    chk_val("pins after reset", 32'h0, 32'(COMPARE_OUT));
    chk_val("enables after reset", 32'h0, 32'(COMPARE_OUT_EN));
    settle(1);
    axi_rd(IDX_CTRL[0], d, r);
    chk_val("mode after reset", 32'h0, d);
    $display("test second reset done");
    close_out();
  end
endmodule // tb_top
